/* pfs_pkg.sv */
/*
 * Constants for the bus-port pin-function selector: register byte offsets,
 * control field positions and reset values.
 * Assumes a 32-bit AHB-Lite slave with word-aligned registers.
 */
package pfs_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_DIR_E   = 8'h00;
   localparam logic [7:0] OFS_DATA_E  = 8'h04;
   localparam logic [7:0] OFS_PIN_E   = 8'h08;
   localparam logic [7:0] OFS_DIR_F   = 8'h0c;
   localparam logic [7:0] OFS_DATA_F  = 8'h10;
   localparam logic [7:0] OFS_PIN_F   = 8'h14;
   localparam logic [7:0] OFS_CTRL    = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1c;
   localparam logic [7:0] OFS_MASK    = 8'h20;

   // ------------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------------
   localparam int CTRL_WAIT_IN_EN    = 0;
   localparam int CTRL_BUS_REQUEST_INPUT_OUT_EN   = 1;
   localparam int CTRL_BUS_REL_EN    = 2;
   localparam int CTRL_WIDTH         = 3;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // ------------------------------------------------------------------
   // Status fields: four interrupt-pin falls, one bus-request arrival
   // ------------------------------------------------------------------
   localparam int STAT_BUS_REQ       = 4;
   localparam int STAT_WIDTH         = 5;
   localparam logic [4:0] STAT_RESET = 5'h00;

   // ------------------------------------------------------------------
   // Port reset values and pin positions
   // ------------------------------------------------------------------
   localparam logic [7:0] DIR_RESET   = 8'h00;
   localparam logic [7:0] DATA_RESET  = 8'h00;
   localparam int PIN_CLK_OUT         = 7;
   localparam int PIN_WAIT            = 2;
   localparam int PIN_BUS_ACK         = 1;
   localparam int PIN_BUS_REQ         = 0;

endpackage

/* pfs_pin_select.sv */
/*
 * Pin-function selector for the low data-byte port (E) and the bus-control
 * port (F), with an AHB-Lite register slave and a level interrupt.
 * Assumes the bus controller, mode and bus-width inputs come from logic on
 * clk; pad inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns

// Notes on behaviour
// (R1) Expanded mode: port E is GPIO for 8-bit bus, low data byte for 16-bit.
// (R2) Clock-output pin is a plain input while its direction bit is 0.
// (R3) Expanded mode: clock-output direction bit resets to 1, clock driven.
// (R4) Single-chip mode: clock-output direction bit resets to 0.
// (R5) Expanded: four pins carry bus strobes; single-chip: they are GPIO.
// (R6) Single-chip: four lowest port F pins are GPIO feeding interrupts 3-0.
// (R7) Both wait enables 0 after reset: wait pin is GPIO feeding interrupt 2.
// (R8) Wait-input enable alone: wait pin takes bus wait, still feeds int 2.
// (R9) Request-output enable alone: wait pin drives bus request, feeds int 2.
// (R10) Bus-release enable 0 (reset): two lowest pins GPIO feeding ints 1, 0.
// (R11) Bus-release enable 1: request in, acknowledge out, still feed ints.
// (R12) Software must not set both wait-pin enables at the same time.
module pfs_pin_select (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        modeExpanded,
   input  wire logic        busWide16,
   input  wire logic [7:0]  busDataOut,
   input  wire logic        busDataDrive,
   input  wire logic        addressStrobe,
   input  wire logic        readStrobe,
   input  wire logic        highByteWriteStrobe,
   input  wire logic        lowByteWriteStrobe,
   input  wire logic        busRequestOutput,
   input  wire logic        busAck,
   output logic      [7:0]  busDataIn,
   output logic             waitRequest,
   output logic             busRequestInput,
   output logic      [3:0]  extInterruptN,
   input  wire logic [7:0]  portEIn,
   output logic      [7:0]  portEOut,
   output logic      [7:0]  portEOutEnN,
   input  wire logic [7:0]  portFIn,
   output logic      [7:0]  portFOut,
   output logic      [7:0]  portFOutEnN,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   output logic             irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0]  pinESync1;
   logic [7:0]  pinE;
   logic [7:0]  pinFSync1;
   logic [7:0]  pinF;
   logic [7:0]  pinFPrev;
   logic        busReqPrev;
   logic        expanded;
   logic [7:0]  dirE;
   logic [7:0]  dataE;
   logic [7:0]  dirF;
   logic [7:0]  dataF;
   logic [2:0]  ctrl;
   logic [4:0]  status;
   logic [4:0]  mask;
   logic [4:0]  eventSet;
   logic [4:0]  next_status;
   logic        rdPend;
   logic        wrPend;
   logic [7:0]  rdAddr;
   logic [7:0]  wrAddr;
   logic        statusRead;
   logic [31:0] next_hrdata;
   logic        waitMode;
   logic        breqMode;
   logic        relMode;
   logic        lowByteBus;
   logic        takeReq;

   // ---------------------------------------------------------------
   // Pad synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinESync1 <= 8'hff;
         pinE      <= 8'hff;
         pinFSync1 <= 8'hff;
         pinF      <= 8'hff;
         pinFPrev  <= 8'hff;
      end else begin
         pinESync1 <= portEIn;
         pinE      <= pinESync1;
         pinFSync1 <= portFIn;
         pinF      <= pinFSync1;
         pinFPrev  <= pinF;
      end
   end

   // Mode is followed during reset so the reset value tracks the straps
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         expanded <= modeExpanded;
      end
   end

   // ---------------------------------------------------------------
   // Function select
   // ---------------------------------------------------------------
   // Both wait enables set is undefined; it falls back to GPIO
   assign waitMode   = expanded && ctrl[pfs_pkg::CTRL_WAIT_IN_EN]
                       && !ctrl[pfs_pkg::CTRL_BUS_REQUEST_INPUT_OUT_EN];           // R8
   assign breqMode   = expanded && !ctrl[pfs_pkg::CTRL_WAIT_IN_EN]
                       && ctrl[pfs_pkg::CTRL_BUS_REQUEST_INPUT_OUT_EN];            // R9
   assign relMode    = expanded && ctrl[pfs_pkg::CTRL_BUS_REL_EN];   // R11
   assign lowByteBus = expanded && busWide16;                         // R1

   // Port E: low data byte or GPIO
   always_comb begin
      if (lowByteBus) begin                                           // R1
         portEOut    = busDataOut;
         portEOutEnN = {8{!busDataDrive}};
      end else begin
         portEOut    = dataE;
         portEOutEnN = ~dirE;
      end
   end
   assign busDataIn = pinE;

   // Port F
   always_comb begin
      portFOut    = dataF;
      portFOutEnN = ~dirF;
      // Clock leaves the pad ungated; the pad itself is the only load
      portFOut[pfs_pkg::PIN_CLK_OUT] = clk;                           // R2
      if (expanded) begin                                             // R5
         portFOut[6:3]    = {!addressStrobe, !readStrobe,
                             !highByteWriteStrobe, !lowByteWriteStrobe};
         portFOutEnN[6:3] = 4'h0;
      end
      if (breqMode) begin                                             // R9
         portFOut[pfs_pkg::PIN_WAIT]    = !busRequestOutput;
         portFOutEnN[pfs_pkg::PIN_WAIT] = 1'b0;
      end else if (waitMode) begin                                    // R8
         portFOutEnN[pfs_pkg::PIN_WAIT] = 1'b1;
      end
      if (relMode) begin                                              // R11
         portFOut[pfs_pkg::PIN_BUS_ACK]    = !busAck;
         portFOutEnN[pfs_pkg::PIN_BUS_ACK] = 1'b0;
         portFOutEnN[pfs_pkg::PIN_BUS_REQ] = 1'b1;
      end
   end

   assign waitRequest     = waitMode && !pinF[pfs_pkg::PIN_WAIT];     // R8
   assign busRequestInput = relMode && !pinF[pfs_pkg::PIN_BUS_REQ];   // R11

   // Interrupt 3 is held high in expanded mode, where its pin carries the low-byte strobe
   assign extInterruptN[3]   = expanded ? 1'b1 : pinF[3];             // R6
   assign extInterruptN[2:0] = pinF[2:0];                             // R7 R10

   // ---------------------------------------------------------------
   // Register slave
   // ---------------------------------------------------------------
   assign takeReq   = hsel && hready && htrans[1];
   assign hreadyout = !rdPend;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdPend <= 1'b0;
         wrPend <= 1'b0;
         rdAddr <= 8'h00;
         wrAddr <= 8'h00;
      end else begin
         rdPend <= takeReq && !hwrite;
         wrPend <= takeReq && hwrite;
         if (takeReq) begin
            rdAddr <= haddr[7:0];
            wrAddr <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dirE  <= pfs_pkg::DIR_RESET;
         dataE <= pfs_pkg::DATA_RESET;
         dirF  <= {modeExpanded, 7'h00};                              // R3 R4
         dataF <= pfs_pkg::DATA_RESET;
         ctrl  <= pfs_pkg::CTRL_RESET;                                // R7 R10
         mask  <= pfs_pkg::STAT_RESET;
      end else if (wrPend) begin
         case (wrAddr)
            pfs_pkg::OFS_DIR_E:  dirE  <= hwdata[7:0];
            pfs_pkg::OFS_DATA_E: dataE <= hwdata[7:0];
            pfs_pkg::OFS_DIR_F:  dirF  <= hwdata[7:0];
            pfs_pkg::OFS_DATA_F: dataF <= hwdata[7:0];
            pfs_pkg::OFS_CTRL:   ctrl  <= hwdata[2:0];
            pfs_pkg::OFS_MASK:   mask  <= hwdata[4:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      case (rdAddr)
         pfs_pkg::OFS_DIR_E:  next_hrdata = {24'h0, dirE};
         pfs_pkg::OFS_DATA_E: next_hrdata = {24'h0, dataE};
         pfs_pkg::OFS_PIN_E:  next_hrdata = {24'h0, pinE};
         pfs_pkg::OFS_DIR_F:  next_hrdata = {24'h0, dirF};
         pfs_pkg::OFS_DATA_F: next_hrdata = {24'h0, dataF};
         pfs_pkg::OFS_PIN_F:  next_hrdata = {24'h0, pinF};
         pfs_pkg::OFS_CTRL:   next_hrdata = {29'h0, ctrl};
         pfs_pkg::OFS_STATUS: next_hrdata = {27'h0, status};
         pfs_pkg::OFS_MASK:   next_hrdata = {27'h0, mask};
         default:             next_hrdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0;
      end else if (rdPend) begin
         hrdata <= next_hrdata;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt events
   // ---------------------------------------------------------------
   assign statusRead = rdPend && (rdAddr == pfs_pkg::OFS_STATUS);

   always_comb begin
      eventSet[3]   = !expanded && pinFPrev[3] && !pinF[3];           // R6
      eventSet[2:0] = pinFPrev[2:0] & ~pinF[2:0];                     // R7 R10
      eventSet[pfs_pkg::STAT_BUS_REQ] = busRequestInput && !busReqPrev;
      // A fall landing on the read edge survives the clear
      next_status = (statusRead ? 5'h00 : status) | eventSet;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status     <= pfs_pkg::STAT_RESET;
         busReqPrev <= 1'b0;
      end else begin
         status     <= next_status;
         busReqPrev <= busRequestInput;
      end
   end

   assign irq = |(status & mask);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_clk_pin_input: assert property (@(posedge clk)                   // R2
      !dirF[pfs_pkg::PIN_CLK_OUT] |-> portFOutEnN[pfs_pkg::PIN_CLK_OUT])
      else $error("clock pin driven while direction is input");

   a_clk_reset_exp: assert property (@(posedge clk)                   // R3
      sys_rst && modeExpanded |=> dirF[pfs_pkg::PIN_CLK_OUT]
                                  && !portFOutEnN[pfs_pkg::PIN_CLK_OUT])
      else $error("clock output not enabled after expanded reset");

   a_clk_reset_sc: assert property (@(posedge clk)                    // R4
      sys_rst && !modeExpanded |=> portFOutEnN[pfs_pkg::PIN_CLK_OUT])
      else $error("clock pin not input after single-chip reset");

   a_low_byte_bus: assert property (@(posedge clk) disable iff (sys_rst)
      expanded && busWide16 |->                                       // R1
         portEOutEnN == {8{!busDataDrive}} && portEOut == busDataOut)
      else $error("low byte port not following the bus");

   a_strobe_pins: assert property (@(posedge clk) disable iff (sys_rst)
      expanded |-> portFOutEnN[6:3] == 4'h0                           // R5
                   && portFOut[6] == !addressStrobe)
      else $error("strobe pins not driven in expanded mode");

   a_sc_int_fall: assert property (@(posedge clk) disable iff (sys_rst)
      !expanded && $fell(pinF[3]) |=> status[3])                      // R6
      else $error("interrupt 3 fall lost in single-chip mode");

   a_wait_default: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl == 3'h0 |-> !waitRequest && !busRequestInput               // R7
         && portFOutEnN[2:0] == ~dirF[2:0])
      else $error("wait and release pins not GPIO by default");

   a_wait_input: assert property (@(posedge clk) disable iff (sys_rst)
      waitMode && !pinF[2] |-> waitRequest && portFOutEnN[2])         // R8
      else $error("wait input not taken");

   a_bus_request_input_out: assert property (@(posedge clk) disable iff (sys_rst)
      breqMode |-> !portFOutEnN[2]                                    // R9
                   && portFOut[2] == !busRequestOutput)
      else $error("bus request output not driven");

   a_release_pins: assert property (@(posedge clk) disable iff (sys_rst)
      relMode && $fell(pinF[0]) |-> busRequestInput ##1               // R11
         status[pfs_pkg::STAT_BUS_REQ] && portFOutEnN[1:0] == 2'b01)
      else $error("bus release pins misbehave");

   a_gpio_release: assert property (@(posedge clk) disable iff (sys_rst)
      !relMode |-> !busRequestInput                                   // R10
                   && portFOutEnN[1:0] == ~dirF[1:0])
      else $error("release pins not GPIO with release off");

   a_int3_gated: assert property (@(posedge clk)                      // R6
      disable iff (sys_rst) expanded |-> extInterruptN[3] && !eventSet[3])
      else $error("interrupt 3 not gated in expanded mode");

   a_port_e_gpio: assert property (@(posedge clk)                     // R1
      disable iff (sys_rst) !lowByteBus |->
         portEOutEnN == ~dirE && portEOut == dataE)
      else $error("port E not GPIO on 8-bit bus");

   a_strobe_revert: assert property (@(posedge clk)                   // R5
      disable iff (sys_rst) !expanded |->
         portFOutEnN[6:3] == ~dirF[6:3] && portFOut[6:3] == dataF[6:3])
      else $error("strobe pins not GPIO in single-chip mode");

   a_wait_released: assert property (@(posedge clk)                   // R8
      disable iff (sys_rst) waitMode |-> portFOutEnN[pfs_pkg::PIN_WAIT])
      else $error("wait pin driven while taking bus wait");

   a_ack_follows: assert property (@(posedge clk)                     // R11
      disable iff (sys_rst) relMode |->
         portFOut[pfs_pkg::PIN_BUS_ACK] == !busAck)
      else $error("acknowledge pin not following the grant");

   a_status_clear: assert property (@(posedge clk)
      disable iff (sys_rst) statusRead && eventSet == 5'h00 |=>
         status == 5'h00)
      else $error("status not cleared by its read");

   c_bus_request_input_driven: cover property (@(posedge clk) breqMode && busRequestOutput);
   c_wait_taken: cover property (@(posedge clk) waitRequest);
   c_bus_release: cover property (@(posedge clk) busRequestInput && busAck);
   c_irq_raised: cover property (@(posedge clk) $rose(irq));
   c_status_clear: cover property (@(posedge clk)
      statusRead && |status ##1 status == 5'h00);

endmodule // pfs_pin_select

/* pfs_ext_bus.sv */
/*
 * Far side of ports E and F: bus memories and a second bus master.
 * Assumes active-low output enables; the bench sets what the far side drives.
 */
`timescale 1ns/1ns
module pfs_ext_bus (
   input  wire logic [7:0] portEOut,
   input  wire logic [7:0] portEOutEnN,
   input  wire logic [7:0] portFOut,
   input  wire logic [7:0] portFOutEnN,
   input  wire logic [7:0] extE,
   input  wire logic [7:0] extF,
   output logic      [7:0] portEIn,
   output logic      [7:0] portFIn
);
   // ------------------------------------------------------------------
   // Pad resolution
   // ------------------------------------------------------------------
   // Device wins where it drives, so no contention
   assign portEIn = (portEOut & ~portEOutEnN) | (extE & portEOutEnN);
   // Bus request from the far master enters on F0
   assign portFIn = (portFOut & ~portFOutEnN) | (extF & portFOutEnN);
endmodule // pfs_ext_bus

/* bus_port_pin_function_select_tb_top.sv */
/*
 * Self-checking bench for the pin-function selector.
 * Assumes a single 20 MHz clock and the AHB-Lite map of pfs_pkg.
 */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value %s exp %h got %h", nm, exp, got); \
   end \
end
module bus_port_pin_function_select_tb_top;
   logic        clk, sys_rst, modeExpanded, busWide16, busDataDrive;
   logic        addressStrobe, readStrobe, highByteWriteStrobe;
   logic        lowByteWriteStrobe, busRequestOutput, busAck;
   logic [7:0]  busDataOut, busDataIn, portEIn, portEOut, portEOutEnN;
   logic [7:0]  portFIn, portFOut, portFOutEnN, extE, extF;
   logic        waitRequest, busRequestInput, hsel, hwrite, hready;
   logic        hreadyout, hresp, irq;
   logic [3:0]  extInterruptN;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          error_cnt = 0;
   int          total_checks = 0;

   assign hready = hreadyout;

   pfs_pin_select pfs_pin_select_i (.clk(clk), .sys_rst(sys_rst),
      .modeExpanded(modeExpanded), .busWide16(busWide16),
      .busDataOut(busDataOut), .busDataDrive(busDataDrive),
      .addressStrobe(addressStrobe), .readStrobe(readStrobe),
      .highByteWriteStrobe(highByteWriteStrobe),
      .lowByteWriteStrobe(lowByteWriteStrobe),
      .busRequestOutput(busRequestOutput), .busAck(busAck),
      .busDataIn(busDataIn), .waitRequest(waitRequest),
      .busRequestInput(busRequestInput), .extInterruptN(extInterruptN),
      .portEIn(portEIn), .portEOut(portEOut), .portEOutEnN(portEOutEnN),
      .portFIn(portFIn), .portFOut(portFOut), .portFOutEnN(portFOutEnN),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

   pfs_ext_bus pfs_ext_bus_i (.portEOut(portEOut), .portEOutEnN(portEOutEnN),
      .portFOut(portFOut), .portFOutEnN(portFOutEnN), .extE(extE),
      .extF(extF), .portEIn(portEIn), .portFIn(portFIn));

   // ------------------------------------------------------------------
   // Clock, tasks
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One single transfer; hready sampled at negedge, stable to the edge
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      logic rdy;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do begin
         @(negedge clk);
         rdy = hreadyout;
         @(posedge clk);
      end while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge clk);
         rdy = hreadyout;
         rdv = hrdata;
         @(posedge clk);
      end while (rdy !== 1'b1);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic rst(input logic m);
      @(posedge clk);
      sys_rst <= 1'b1;
      modeExpanded <= m;
      extF <= 8'hff;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      settle(1);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_exp;
      rst(1'b1);
      `CHK("clk dir", 1'b0, portFOutEnN[7])
      `CHK("strb en", 4'h0, portFOutEnN[6:3])
      @(posedge clk);
      {addressStrobe, readStrobe, highByteWriteStrobe} <= 3'h5;
      lowByteWriteStrobe <= 1'b1;
      settle(3);
      `CHK("strb pin", 4'h4, portFOut[6:3])
      `CHK("int3 off", 1'b1, extInterruptN[3])
      `CHK("E idle", 8'hff, portEOutEnN)
      ahb(1'b1, pfs_pkg::OFS_DIR_E, 32'hff);
      ahb(1'b1, pfs_pkg::OFS_DATA_E, 32'ha5);
      settle(1);
      `CHK("E gpio", 8'ha5, portEOut)
      @(posedge clk);
      busWide16 <= 1'b1;
      busDataDrive <= 1'b1;
      settle(1);
      `CHK("E bus", 8'h3c, portEOut)
      `CHK("E bus en", 8'h00, portEOutEnN)
      @(posedge clk);
      busDataDrive <= 1'b0;
      extE <= 8'h5a;
      settle(5);
      `CHK("E rel", 8'hff, portEOutEnN)
      `CHK("E in", 8'h5a, busDataIn)
   endtask

   task automatic t_wait;
      ahb(1'b1, pfs_pkg::OFS_MASK, 32'h0);
      extF <= 8'hfb;
      settle(5);
      `CHK("no wait", 1'b0, waitRequest)
      `CHK("int2", 1'b0, extInterruptN[2])
      `CHK("masked", 1'b0, irq)
      ahb(1'b1, pfs_pkg::OFS_MASK, 32'h1f);
      settle(1);
      `CHK("irq", 1'b1, irq)
      ahb(1'b0, pfs_pkg::OFS_STATUS, 32'h0);
      `CHK("stat", 32'h4, rdv)
      settle(1);
      `CHK("irq clr", 1'b0, irq)
      // Never both wait enables: pin function undefined then
      ahb(1'b1, pfs_pkg::OFS_CTRL, 32'h1);
      settle(1);
      `CHK("wait", 1'b1, waitRequest)
      `CHK("wait int", 1'b0, extInterruptN[2])
      @(posedge clk);
      extF <= 8'hff;
      settle(5);
      `CHK("wait off", 1'b0, waitRequest)
      ahb(1'b1, pfs_pkg::OFS_CTRL, 32'h2);
      busRequestOutput <= 1'b1;
      settle(5);
      `CHK("req en", 1'b0, portFOutEnN[2])
      `CHK("req pin", 1'b0, portFOut[2])
      `CHK("req int", 1'b0, extInterruptN[2])
   endtask

   task automatic t_rel;
      ahb(1'b1, pfs_pkg::OFS_CTRL, 32'h0);
      busRequestOutput <= 1'b0;
      extF <= 8'hfe;
      settle(5);
      ahb(1'b0, pfs_pkg::OFS_STATUS, 32'h0);
      `CHK("no bus_request_input", 1'b0, busRequestInput)
      `CHK("int0", 1'b0, extInterruptN[0])
      ahb(1'b1, pfs_pkg::OFS_CTRL, 32'h4);
      busAck <= 1'b1;
      settle(5);
      `CHK("bus_request_input", 1'b1, busRequestInput)
      `CHK("ack en", 1'b0, portFOutEnN[1])
      `CHK("ack pin", 1'b0, portFOut[1])
      `CHK("int1", 1'b0, extInterruptN[1])
      ahb(1'b0, pfs_pkg::OFS_STATUS, 32'h0);
      `CHK("stat", 32'h12, rdv)
      extF <= 8'hff;
      settle(5);
      `CHK("bus_request_input off", 1'b0, busRequestInput)
      @(posedge clk);
      extF <= 8'hfe;
      settle(5);
      ahb(1'b0, pfs_pkg::OFS_STATUS, 32'h0);
      `CHK("stat rel", 32'h11, rdv)
   endtask

   task automatic t_single;
      busAck <= 1'b0;
      rst(1'b0);
      `CHK("clk in", 1'b1, portFOutEnN[7])
      `CHK("strb io", 4'hf, portFOutEnN[6:3])
      @(posedge clk);
      extF <= 8'h7f;
      settle(5);
      ahb(1'b0, pfs_pkg::OFS_PIN_F, 32'h0);
      `CHK("F7 in", 32'h7f, rdv)
      ahb(1'b1, pfs_pkg::OFS_MASK, 32'h8);
      ahb(1'b1, pfs_pkg::OFS_DIR_F, 32'h8);
      settle(5);
      `CHK("F3 drv", 1'b0, portFOutEnN[3])
      `CHK("int3", 1'b0, extInterruptN[3])
      `CHK("ext_interrupt_3", 1'b1, irq)
      ahb(1'b0, pfs_pkg::OFS_STATUS, 32'h0);
      `CHK("stat", 32'h8, rdv)
      ahb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rdv)
      `CHK("resp", 1'b0, hresp)
   endtask

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      {sys_rst, modeExpanded, busWide16, busDataDrive, busAck} = 5'h18;
      {addressStrobe, readStrobe, highByteWriteStrobe} = 3'h0;
      {lowByteWriteStrobe, busRequestOutput, hsel, hwrite} = 4'h0;
      {busDataOut, extE, extF, haddr, hwdata} = {8'h3c, 8'h0, 8'hff, 64'h0};
      htrans = 2'h0;
      hsize = 3'h2;
      t_exp();
      t_wait();
      t_rel();
      t_single();
      end_of_test();
   end

   initial begin
      #500000;
      error_cnt++;
      end_of_test();
   end
endmodule // bus_port_pin_function_select_tb_top
